// *** src/boost_bypass_config_status_regs.v ***
// Register bank of the boost/pass-through converter: threshold, current limit and status
//
// Functional notes
// - Upper threshold code in bits 4:0 at 0x03, 2.850V to 4.400V in 50 mV steps.
// - Current-limit bits 7:6 ignore writes and read back zero.
// - Current-limit bit 5 set disables current limiting; resets to zero.
// - Bit 4 selects soft-start: one fixes about 1250mA, zero follows limit code; resets one.
// - Bits 3:0 give valley limit, 1000 is 1500mA up to 1111 at 5000mA.
// - Status bit 7 latches on thermal trip, clears after status read.
// - Status bit 5 shows live pulse-frequency mode.
// - Status bit 4 shows live converter operation, zero in pass-through.
// - Status bit 3 latches bypass switch overcurrent in pass-through only, clears after status read.
// - Status bit 2 latches after 1.5ms continuous boost input limit, clears on read.
// - Status bit 1 latches on any fault, clears after status read.
// - Status bit 0 shows regulation good, forced one in forced pass-through.
`timescale 1ns/1ps
`include "boost_bypass_regs.vh"

module boost_bypass_config_status_regs #(
    parameter BST_OC_CYCLES = `BST_OC_CYCLES,
    parameter CNT_W         = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // Register access port from the serial interface
    input  wire [7:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    // Pin-level events and live states from the analog side
    input  wire             thermal_trip,
    input  wire             hot_junction,
    input  wire             pfm_mode,
    input  wire             converter_on,
    input  wire             bypass_oc,
    input  wire             boost_oc,
    input  wire             fault_event,
    input  wire             output_good,
    input  wire             forced_bypass,
    // Settings to the regulation loop
    output reg  [4:0]       upper_threshold_code,
    output reg              limit_disable,
    output reg              softstart_fixed,
    output reg  [3:0]       valley_limit_code
);

    // ************************************************************
    // Reset values
    // ************************************************************
    // Reset images of the writable fields, sized to the stored bits
    localparam [4:0] THR_RST = `RST_UPPER_THRESHOLD;
    localparam [5:0] LIM_RST = `RST_CURRENT_LIMIT;

    // ************************************************************
    // Address decode
    // ************************************************************
    // True when an access targets the given offset
    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam N_IN = 9;
    wire [N_IN-1:0] raw_in = {thermal_trip, hot_junction, pfm_mode, converter_on,
                              bypass_oc, boost_oc, fault_event, output_good, forced_bypass};
    reg  [N_IN-1:0] sync1_r;
    reg  [N_IN-1:0] sync2_r;
    reg  [N_IN-1:0] sync3_r;
    reg  [N_IN-1:0] stable_r;
    // Stages two and three hold the same value
    wire [N_IN-1:0] agree_w = ~(sync2_r ^ sync3_r);

    // Three stages; a level is taken once stages two and three agree
    always @(posedge clk) begin
        if (!rst_b) begin
            sync1_r  <= {N_IN{1'b0}};
            sync2_r  <= {N_IN{1'b0}};
            sync3_r  <= {N_IN{1'b0}};
            stable_r <= {N_IN{1'b0}};
        end else begin
            sync1_r  <= raw_in;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            stable_r <= (sync3_r & agree_w) | (stable_r & ~agree_w);
        end
    end

    wire s_thermal = stable_r[8];
    wire s_hot     = stable_r[7];
    wire s_pfm     = stable_r[6];
    wire s_conv    = stable_r[5];
    wire s_byp_oc  = stable_r[4];
    wire s_bst_oc  = stable_r[3];
    wire s_fault   = stable_r[2];
    wire s_good    = stable_r[1];
    wire s_forced  = stable_r[0];

    // ************************************************************
    // Boost overcurrent qualification
    // ************************************************************
    wire bst_oc_long;

    // Input limit must persist 1.5ms while boosting
    boost_oc_qualifier #(
        .CNT_W  (CNT_W),
        .CYCLES (BST_OC_CYCLES)
    ) u_bst_qual (
        .clk       (clk),
        .rst_b     (rst_b),
        .level_in  (s_bst_oc & s_conv),
        .qualified (bst_oc_long)
    );

    // ************************************************************
    // Event edge detection
    // ************************************************************
    reg  thermal_d_r;
    reg  byp_oc_d_r;
    reg  bst_long_d_r;
    reg  fault_d_r;

    // Past values for rising-edge events
    always @(posedge clk) begin
        if (!rst_b) begin
            thermal_d_r  <= 1'b0;
            byp_oc_d_r   <= 1'b0;
            bst_long_d_r <= 1'b0;
            fault_d_r    <= 1'b0;
        end else begin
            thermal_d_r  <= s_thermal;
            byp_oc_d_r   <= s_byp_oc;
            bst_long_d_r <= bst_oc_long;
            fault_d_r    <= s_fault;
        end
    end

    wire ev_thermal = s_thermal & ~thermal_d_r;
    wire ev_byp_oc  = s_byp_oc & ~byp_oc_d_r & ~s_conv;
    wire ev_bst_oc  = bst_oc_long & ~bst_long_d_r;
    wire ev_fault   = (s_fault & ~fault_d_r) | ev_thermal | ev_byp_oc | ev_bst_oc;

    // ************************************************************
    // Writable registers
    // ************************************************************
    wire wr_thr = reg_wr && addr_hit(reg_addr, `OFS_UPPER_THRESHOLD);
    wire wr_lim = reg_wr && addr_hit(reg_addr, `OFS_CURRENT_LIMIT);

    // Store only implemented bits; reserved bits are dropped
    always @(posedge clk) begin
        if (!rst_b) begin
            upper_threshold_code <= THR_RST;
            limit_disable        <= LIM_RST[`LIM_DISABLE_BIT];
            softstart_fixed      <= LIM_RST[`LIM_SOFTSTART_BIT];
            valley_limit_code    <= LIM_RST[`LIM_CODE_MSB:0];
        end else begin
            if (wr_thr)
                upper_threshold_code <= reg_wdata[`THR_CODE_MSB:0];
            if (wr_lim) begin
                limit_disable     <= reg_wdata[`LIM_DISABLE_BIT];
                softstart_fixed   <= reg_wdata[`LIM_SOFTSTART_BIT];
                valley_limit_code <= reg_wdata[`LIM_CODE_MSB:0];
            end
        end
    end

    // ************************************************************
    // Status flags and read path
    // ************************************************************
    reg  thermal_flag_r;
    reg  byp_oc_flag_r;
    reg  bst_oc_flag_r;
    reg  fault_flag_r;
    wire rd_status = reg_rd && addr_hit(reg_addr, `OFS_STATUS);

    // Sticky flags; a new event in the read cycle wins over the clear
    always @(posedge clk) begin
        if (!rst_b) begin
            thermal_flag_r <= 1'b0;
            byp_oc_flag_r  <= 1'b0;
            bst_oc_flag_r  <= 1'b0;
            fault_flag_r   <= 1'b0;
        end else begin
            thermal_flag_r <= ev_thermal | (thermal_flag_r & ~rd_status);
            byp_oc_flag_r  <= ev_byp_oc  | (byp_oc_flag_r  & ~rd_status);
            bst_oc_flag_r  <= ev_bst_oc  | (bst_oc_flag_r  & ~rd_status);
            fault_flag_r   <= ev_fault   | (fault_flag_r   & ~rd_status);
        end
    end

    wire [7:0] status_word = {thermal_flag_r, s_hot,
                              s_pfm,
                              s_conv,
                              byp_oc_flag_r, bst_oc_flag_r, fault_flag_r,
                              s_good | s_forced};

    // Readback words; reserved positions always read zero
    wire [7:0] thr_word = {3'h0, upper_threshold_code};
    wire [7:0] lim_word = {2'h0, limit_disable, softstart_fixed, valley_limit_code};

    // Registered read data; unmapped addresses read zero
    always @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= `RST_STATUS;
        end else if (reg_rd) begin
            if (addr_hit(reg_addr, `OFS_UPPER_THRESHOLD))
                reg_rdata <= thr_word;
            else if (addr_hit(reg_addr, `OFS_CURRENT_LIMIT))
                reg_rdata <= lim_word;
            else if (addr_hit(reg_addr, `OFS_STATUS))
                reg_rdata <= status_word;
            else
                reg_rdata <= 8'h00;
        end
    end

endmodule // boost_bypass_config_status_regs

// *** src/boost_bypass_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the boost/bypass register bank
`ifndef BOOST_BYPASS_REGS_VH
`define BOOST_BYPASS_REGS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_UPPER_THRESHOLD    8'h03
`define OFS_CURRENT_LIMIT      8'h04
`define OFS_STATUS             8'h05

// ************************************************************
// Field positions
// ************************************************************
`define THR_CODE_MSB           4
`define LIM_DISABLE_BIT        5
`define LIM_SOFTSTART_BIT      4
`define LIM_CODE_MSB           3
`define ST_THERMAL_BIT         7
`define ST_HOT_BIT             6
`define ST_PFM_BIT             5
`define ST_CONV_BIT            4
`define ST_BYP_OC_BIT          3
`define ST_BST_OC_BIT          2
`define ST_FAULT_BIT           1
`define ST_OUTPUT_IN_REGULATION_BIT           0

// ************************************************************
// Reset values
// ************************************************************
`define RST_UPPER_THRESHOLD    5'h0A
`define RST_CURRENT_LIMIT      6'h1B
`define RST_STATUS             8'h00

// ************************************************************
// Timing
// ************************************************************
`define BST_OC_TIME_NS         1500000
`define CLK_PERIOD_NS          40
`define BST_OC_CYCLES          (`BST_OC_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** src/boost_oc_qualifier.v ***
// Qualifier that fires once a level has held continuously for a set number of cycles
`timescale 1ns/1ps

module boost_oc_qualifier #(
    parameter CNT_W  = 16,
    parameter CYCLES = 37500
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // Level to qualify and result
    input  wire             level_in,
    output reg              qualified
);

    reg  [CNT_W-1:0]        cnt_r;
    // Terminal count, cut on purpose to the counter width
    localparam [31:0]       LAST_I = CYCLES - 1;
    localparam [CNT_W-1:0]  LAST   = LAST_I[CNT_W-1:0];

    // Count while level holds; restart on any drop
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_r     <= {CNT_W{1'b0}};
            qualified <= 1'b0;
        end else if (!level_in) begin
            cnt_r     <= {CNT_W{1'b0}};
            qualified <= 1'b0;
        end else begin
            if (cnt_r != LAST)
                cnt_r <= cnt_r + 1'b1;
            qualified <= (cnt_r == LAST) ? 1'b1 : 1'b0;
        end
    end

endmodule // boost_oc_qualifier

// *** tb/bbr_props.sv ***
// Checker of the register bank port behaviour
`timescale 1ns/1ps
`include "boost_bypass_regs.vh"
module bbr_props (
    // Clock and reset
    input wire       clk,
    input wire       rst_b,
    // Register access
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Live levels
    input wire       pfm_mode,
    input wire       converter_on,
    input wire       forced_bypass,
    // Settings
    input wire [4:0] upper_threshold_code,
    input wire       limit_disable,
    input wire       softstart_fixed,
    input wire [3:0] valley_limit_code
);
    // *****
    // Properties
    // *****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    thr_write_a: assert property (reg_wr && reg_addr == `OFS_UPPER_THRESHOLD |=>
        {3'h0, upper_threshold_code} == ($past(reg_wdata) & 8'h1F)) else $error("threshold write lost");
    lim_write_a: assert property (reg_wr && reg_addr == `OFS_CURRENT_LIMIT |=>
        {2'h0, limit_disable, softstart_fixed, valley_limit_code} == ($past(reg_wdata) & 8'h3F))
        else $error("limit write lost");
    lim_resv_a: assert property (reg_rd && reg_addr == `OFS_CURRENT_LIMIT |=> reg_rdata[7:6] == 2'h0)
        else $error("limit reserved bits set");
    thr_resv_a: assert property (reg_rd && reg_addr == `OFS_UPPER_THRESHOLD |=> reg_rdata[7:5] == 3'h0)
        else $error("threshold reserved bits set");
    unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h03 || reg_addr > 8'h05) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    pfm_live_a: assert property (pfm_mode [*6] ##0 (reg_rd && reg_addr == `OFS_STATUS) |=> reg_rdata[5])
        else $error("pulse mode bit low");
    conv_live_a: assert property (!converter_on [*6] ##0 (reg_rd && reg_addr == `OFS_STATUS)
        |=> !reg_rdata[4]) else $error("converter bit high in pass-through");
    forced_good_a: assert property (forced_bypass [*6] ##0 (reg_rd && reg_addr == `OFS_STATUS)
        |=> reg_rdata[0]) else $error("regulation bit low when forced");
    // Main scenarios
    cov_thermal: cover property (reg_rd && reg_addr == `OFS_STATUS ##1 reg_rdata[7]);
    cov_boost: cover property (reg_rd && reg_addr == `OFS_STATUS ##1 reg_rdata[2]);
    cov_limit: cover property (reg_wr && reg_addr == `OFS_CURRENT_LIMIT);
endmodule // bbr_props
bind boost_bypass_config_status_regs bbr_props chk_i (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pfm_mode, .converter_on, .forced_bypass, .upper_threshold_code, .limit_disable,
    .softstart_fixed, .valley_limit_code);

// *** tb/host_model.sv ***
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire       clk,
    // Register access
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        reg_wr,
    output reg        reg_rd,
    input  wire [7:0] reg_rdata
);
    // *****
    // Access tasks
    // *****
    initial begin
        reg_addr = 8'hA5;
        reg_wdata = 8'h5A;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One strobe edge per access; idle lines scrambled so stale values never match
    task acc(input w, input [7:0] a, input [7:0] v, output [7:0] q);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = v;
            reg_wr = w;
            reg_rd = !w;
            @(negedge clk);
            q = reg_rdata;
            reg_wr = 1'b0;
            reg_rd = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~v;
        end
    endtask
endmodule // host_model

// *** tb/boost_bypass_config_status_regs_tb.sv ***
// Self-checking bench of the register bank
`timescale 1ns/1ps
`include "boost_bypass_regs.vh"
module boost_bypass_config_status_regs_tb;
    reg        clk = 1'b0;
    reg        rst_b = 1'b0;
    reg  [8:0] ana = 9'h000; // Analog levels in port order
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire       reg_wr, reg_rd, l_dis, ss_fix;
    wire [4:0] thr;
    wire [3:0] vlc;
    reg  [7:0] d;
    integer    bad_count = 0;
    integer    checks = 0;
    integer    cyc = 0;
    // *****
    // Harness
    // *****
    always #20 clk = ~clk;
    host_model host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    boost_bypass_config_status_regs #(.BST_OC_CYCLES(20)) dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .thermal_trip(ana[8]), .hot_junction(ana[7]), .pfm_mode(ana[6]),
        .converter_on(ana[5]), .bypass_oc(ana[4]), .boost_oc(ana[3]), .fault_event(ana[2]),
        .output_good(ana[1]), .forced_bypass(ana[0]), .upper_threshold_code(thr), .limit_disable(l_dis),
        .softstart_fixed(ss_fix), .valley_limit_code(vlc));
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            bad_count = bad_count + 1;
            close_out;
        end
    end
    task chk(input [47:0] nm, input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d bad_count %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        begin
            host.acc(1'b0, a, 8'h00, d);
            chk("read", d, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        host.acc(1'b1, a, v, d);
    endtask
    task lv(input [8:0] v, input integer n);
        begin
            ana = v;
            repeat (n) @(negedge clk);
        end
    endtask
    // Pulse an event, then read twice: latched once, cleared after readout
    task ev(input [8:0] v, input [7:0] exp);
        begin
            lv(v, 2);
            lv(v & 9'h020, 8);
            rc(`OFS_STATUS, exp);
            rc(`OFS_STATUS, exp & 8'h10);
            lv(9'h000, 8);
        end
    endtask
    // *****
    // Scenarios
    // *****
    task t_reset;
        begin
            rc(`OFS_UPPER_THRESHOLD, 8'h0A);
            rc(`OFS_CURRENT_LIMIT, 8'h1B);
            rc(`OFS_STATUS, 8'h00);
        end
    endtask
    task t_config;
        begin
            wr(`OFS_UPPER_THRESHOLD, 8'hFF);
            rc(`OFS_UPPER_THRESHOLD, 8'h1F);
            chk("thr", {3'h0, thr}, 8'h1F);
            wr(`OFS_UPPER_THRESHOLD, 8'hE0);
            rc(`OFS_UPPER_THRESHOLD, 8'h00);
            wr(`OFS_CURRENT_LIMIT, 8'hFF);
            rc(`OFS_CURRENT_LIMIT, 8'h3F);
            chk("lim", {2'h0, l_dis, ss_fix, vlc}, 8'h3F);
            wr(`OFS_CURRENT_LIMIT, 8'hC8);
            rc(`OFS_CURRENT_LIMIT, 8'h08);
            wr(`OFS_STATUS, 8'hFF);
            wr(8'h07, 8'hFF);
            rc(8'h07, 8'h00);
            rc(`OFS_STATUS, 8'h00);
            rc(`OFS_CURRENT_LIMIT, 8'h08);
        end
    endtask
    task t_status;
        begin
            lv(9'h0E2, 8);
            rc(`OFS_STATUS, 8'h71);
            lv(9'h001, 8);
            rc(`OFS_STATUS, 8'h01);
            ev(9'h100, 8'h82);
            ev(9'h010, 8'h0A);
            ev(9'h030, 8'h10);
            ev(9'h004, 8'h02);
            lv(9'h028, 10);
            lv(9'h020, 8);
            rc(`OFS_STATUS, 8'h10);
            lv(9'h028, 30);
            lv(9'h020, 8);
            rc(`OFS_STATUS, 8'h16);
            rc(`OFS_STATUS, 8'h10);
        end
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset;
        t_config;
        t_status;
        close_out;
    end
endmodule // boost_bypass_config_status_regs_tb
